// file: src/pcfl_flash.sv
`timescale 1ns/100ps
`include "pcfl_map.svh"

// flash side of the parallel burst configuration link
module pcfl_flash_top import pcfl_pkg::*; (
  input  wire logic                    CLK_IN,
  input  wire logic                    SRST_IN,
  input  wire logic                    LINK_CLK_IN,
  input  wire logic [`PCFL_ADDR_W-1:0] ADDR_IN,
  input  wire logic                    SEL_N_IN,
  input  wire logic                    OUT_EN_N_IN,
  input  wire logic                    WRITE_EN_N_IN,
  input  wire logic                    PROG_WE_IN,
  input  wire logic [`PCFL_IDX_W-1:0]  PROG_ADDR_IN,
  input  wire logic [`PCFL_DATA_W-1:0] PROG_DATA_IN,
  output logic      [`PCFL_DATA_W-1:0] DATA_OUT,
  output logic                         DATA_OE_OUT,
  output logic                         READY_OUT
);

  // ----------------------------------------------------------------
  // system domain: power-up ready timer
  // ----------------------------------------------------------------
  localparam pcfl_sys_type SYS_RST = '{default: '0};

  pcfl_sys_type sys_q;
  pcfl_sys_type sys_d;

  always_comb begin
    sys_d = sys_q;
    if (sys_q.cnt == pcfl_rdy_cnt_type'(`PCFL_READY_CYC)) begin
      sys_d.ready = 1'b1;
    end else begin
      sys_d.cnt = sys_q.cnt + 1'b1;
    end
    if (SRST_IN) begin
      sys_d = SYS_RST;
    end
  end

  always_ff @(posedge CLK_IN) begin
    sys_q <= sys_d;
  end

  assign READY_OUT = sys_q.ready; // straight from the ready flop

  // ----------------------------------------------------------------
  // crossings into the link domain
  // ----------------------------------------------------------------
  logic rst_l;
  logic rdy_s;

  // reset is a slow level, so a plain level crossing is enough
  pcfl_sync #(.WIDTH(1)) u_rst_sync (
    .clk_in (LINK_CLK_IN),
    .d_in   (SRST_IN),
    .q_out  (rst_l)
  );

  // ready leaves a flop, so no glitch can reach the chain
  pcfl_sync #(.WIDTH(1)) u_rdy_sync (
    .clk_in (LINK_CLK_IN),
    .d_in   (sys_q.ready),
    .q_out  (rdy_s)
  );

  // ----------------------------------------------------------------
  // link domain: address latch and burst read
  // ----------------------------------------------------------------
  localparam pcfl_link_type LINK_RST = '{state: LS_WAIT_READY, default: '0};

  pcfl_link_type lnk_q;
  pcfl_link_type lnk_d;
  pcfl_word_type rd_word;
  pcfl_addr_type addr_inc;
  logic          drive_ok;

  assign rd_word  = lnk_q.mem[pcfl_idx(lnk_q.addr)];
  assign addr_inc = lnk_q.addr + 1'b1;
  assign drive_ok = !SEL_N_IN && !OUT_EN_N_IN && WRITE_EN_N_IN;

  always_comb begin
    lnk_d = lnk_q;
    case (lnk_q.state)
      LS_WAIT_READY: begin
        lnk_d.cnt = '0;
        lnk_d.oe  = 1'b0;
        if (rdy_s) begin
          lnk_d.state = LS_LATCH_WAIT;
        end
      end
      LS_LATCH_WAIT: begin
        if (lnk_q.cnt == pcfl_cnt_type'(`PCFL_LATCH_WAIT - 1)) begin
          lnk_d.addr  = ADDR_IN;
          lnk_d.cnt   = '0;
          lnk_d.state = LS_LATENCY;
        end else begin
          lnk_d.cnt = lnk_q.cnt + 1'b1;
        end
      end
      LS_LATENCY: begin
        if (lnk_q.cnt == pcfl_cnt_type'(`PCFL_READ_LAT - 1)) begin
          lnk_d.state = LS_BURST;
          lnk_d.data  = rd_word;
          lnk_d.addr  = addr_inc;
          lnk_d.oe    = drive_ok;
        end else begin
          lnk_d.cnt = lnk_q.cnt + 1'b1;
        end
      end
      LS_BURST: begin
        lnk_d.data = rd_word;
        lnk_d.addr = addr_inc;
        lnk_d.oe   = drive_ok;
        if (SEL_N_IN) begin
          lnk_d.state = LS_STOPPED;
          lnk_d.oe    = 1'b0;
        end
      end
      LS_STOPPED: begin
        lnk_d.oe = 1'b0; // parked until ready drops again
      end
      default: begin
        lnk_d = LINK_RST;
      end
    endcase
    // losing ready aborts any read in progress
    if (!rdy_s) begin
      lnk_d.state = LS_WAIT_READY;
      lnk_d.cnt   = '0;
      lnk_d.oe    = 1'b0;
    end
    // array loads are refused while a read walks it, so the stream never tears
    if (PROG_WE_IN && lnk_q.state != LS_LATENCY && lnk_q.state != LS_BURST) begin
      lnk_d.mem[PROG_ADDR_IN] = PROG_DATA_IN;
    end
    if (rst_l) begin
      lnk_d = LINK_RST;
    end
  end

  always_ff @(posedge LINK_CLK_IN) begin
    lnk_q <= lnk_d;
  end

  assign DATA_OUT    = lnk_q.data;
  assign DATA_OE_OUT = lnk_q.oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_READY_HELD_LOW: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    (sys_q.cnt != pcfl_rdy_cnt_type'(`PCFL_READY_CYC)) |-> !READY_OUT
  ) else $error("ready raised before the power-up delay ran out");

  AST_READY_RISES: assert property (
    @(posedge CLK_IN) disable iff (SRST_IN)
    $rose(SRST_IN == 1'b0) |-> !READY_OUT ##21 READY_OUT
  ) else $error("ready did not rise after the power-up delay");

  AST_LATCH_AFTER_THREE: assert property (
    @(posedge LINK_CLK_IN) disable iff (rst_l)
    (lnk_q.state == LS_WAIT_READY && rdy_s) ##1 rdy_s[*3] |=> (lnk_q.state == LS_LATENCY)
  ) else $error("start address not latched three cycles after ready");

  AST_ADDR_LATCHED: assert property (
    @(posedge LINK_CLK_IN) disable iff (rst_l)
    (lnk_q.state == LS_LATCH_WAIT && lnk_q.cnt == pcfl_cnt_type'(`PCFL_LATCH_WAIT - 1) && rdy_s)
      |=> lnk_q.addr == $past(ADDR_IN)
  ) else $error("address counter did not take the start address");

  AST_NO_EARLY_LATCH: assert property (
    @(posedge LINK_CLK_IN) disable iff (rst_l)
    (lnk_q.state == LS_WAIT_READY) |=> lnk_q.state != LS_LATENCY ##1 lnk_q.state != LS_LATENCY
  ) else $error("address latched too early after ready");

  AST_FIRST_WORD: assert property (
    @(posedge LINK_CLK_IN) disable iff (rst_l)
    (lnk_q.state == LS_LATENCY && lnk_q.cnt == '0 && rdy_s) ##1 rdy_s
      |=> lnk_q.state == LS_BURST && lnk_q.data == $past(rd_word)
  ) else $error("first word late or not from the start address");

  AST_BURST_STEP: assert property (
    @(posedge LINK_CLK_IN) disable iff (rst_l)
    (lnk_q.state == LS_BURST && rdy_s && !SEL_N_IN)
      |=> lnk_q.addr == $past(addr_inc) && lnk_q.data == $past(rd_word)
  ) else $error("burst did not advance to the next word");

  AST_DESELECT_STOPS: assert property (
    @(posedge LINK_CLK_IN) disable iff (rst_l)
    SEL_N_IN |=> !DATA_OE_OUT
  ) else $error("bus still driven after deselect");

  AST_STOPPED_HOLDS: assert property (
    @(posedge LINK_CLK_IN) disable iff (rst_l)
    (lnk_q.state == LS_BURST && SEL_N_IN && rdy_s) |=> (lnk_q.state == LS_STOPPED && !DATA_OE_OUT)[*2]
  ) else $error("flash resumed driving after deselect");

  AST_DRIVE_ONLY_BURST: assert property (
    @(posedge LINK_CLK_IN) disable iff (rst_l)
    DATA_OE_OUT |-> lnk_q.state == LS_BURST && $past(drive_ok)
  ) else $error("bus driven outside a burst or without enables");

endmodule : pcfl_flash_top

// file: include/pcfl_map.svh
`ifndef PCFL_MAP_SVH
`define PCFL_MAP_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define PCFL_ADDR_W        23
`define PCFL_DATA_W        16
`define PCFL_MEM_DEPTH     16
`define PCFL_IDX_W         4
`define PCFL_CNT_W         2
`define PCFL_RDY_CNT_W     8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCFL_LATCH_WAIT    3
`define PCFL_READ_LAT      2
`define PCFL_CLK_PERIOD_NS 5
`define PCFL_READY_TIME_NS 100
`define PCFL_READY_CYC     ((`PCFL_READY_TIME_NS + `PCFL_CLK_PERIOD_NS - 1) / `PCFL_CLK_PERIOD_NS)

`endif

// file: include/pcfl_pkg.sv
`include "pcfl_map.svh"

package pcfl_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [`PCFL_ADDR_W-1:0]    pcfl_addr_type;
  typedef logic [`PCFL_DATA_W-1:0]    pcfl_word_type;
  typedef logic [`PCFL_IDX_W-1:0]     pcfl_idx_type;
  typedef logic [`PCFL_CNT_W-1:0]     pcfl_cnt_type;
  typedef logic [`PCFL_RDY_CNT_W-1:0] pcfl_rdy_cnt_type;

  typedef enum logic [2:0] {
    LS_WAIT_READY,
    LS_LATCH_WAIT,
    LS_LATENCY,
    LS_BURST,
    LS_STOPPED
  } pcfl_link_state_type;

  // link-side state: wait counter, address counter, array and bus drive
  typedef struct packed {
    pcfl_link_state_type                          state;
    pcfl_cnt_type                                 cnt;
    pcfl_addr_type                                addr;
    pcfl_word_type                                data;
    logic                                         oe;
    logic [`PCFL_MEM_DEPTH-1:0][`PCFL_DATA_W-1:0] mem;
  } pcfl_link_type;

  // system-side state: power-up ready timer
  typedef struct packed {
    pcfl_rdy_cnt_type cnt;
    logic             ready;
  } pcfl_sys_type;

  // array index from the address counter; upper bits alias
  function automatic pcfl_idx_type pcfl_idx(input pcfl_addr_type a);
    return a[`PCFL_IDX_W-1:0];
  endfunction : pcfl_idx

endpackage : pcfl_pkg

// file: src/pcfl_sync.sv
`timescale 1ns/100ps

// three-stage synchroniser; the output moves once stages two and three agree
module pcfl_sync import pcfl_pkg::*; #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] val;
  } pcfl_sync_type;

  pcfl_sync_type q;
  pcfl_sync_type d;

  // shift chain; first stage feeds only the second
  always_comb begin
    d    = q;
    d.s1 = d_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.val = q.s3;
    end
  end

  always_ff @(posedge clk_in) begin
    q <= d;
  end

  assign q_out = q.val;

endmodule : pcfl_sync

// file: test/pcfl_loader_model.sv
`timescale 1ns/100ps
`include "pcfl_map.svh"

// loader end of the link: holds the flash enables, captures each word and keeps
// the loader's own configuration status as far as the bench looks at it
module pcfl_loader_model import pcfl_pkg::*; (
  input  wire logic                    link_clk_in,
  input  wire logic                    prog_n_in,
  input  wire logic                    crc_err_in,
  input  wire logic                    io_pullup_disable_in,
  input  wire logic [`PCFL_DATA_W-1:0] data_in,
  input  wire logic                    data_oe_in,
  input  wire logic [`PCFL_ADDR_W-1:0] start_addr_in,
  input  wire logic                    quiet_in,
  input  wire logic                    done_in,
  output logic      [`PCFL_ADDR_W-1:0] addr_out,
  output logic                         sel_n_out,
  output logic                         out_en_n_out,
  output logic                         write_en_n_out
);
  localparam int         BITSTREAM_WORDS = 20;   // bitstream length used in the bench
  localparam logic [2:0] MODE_PINS       = 3'h6; // strapped mode, value arbitrary

  logic [`PCFL_DATA_W-1:0] words[$];
  logic                    init_n             = 1'b0;
  logic                    busy_n             = 1'b1;
  logic                    startup            = 1'b0;
  logic                    done_pin           = 1'b0;
  logic                    user_pins_live     = 1'b0;
  logic                    chain_select_out_n = 1'b1;
  logic                    revision_select_oe = 1'b0;
  logic [2:0]              mode               = 3'h0;
  logic                    unused_pull_up;

  // settled levels before the first link edge
  initial begin
    addr_out       = '0;
    sel_n_out      = 1'b0;
    out_en_n_out   = 1'b0;
    write_en_n_out = 1'b1;
  end

  // enables held steady
  // moves on the falling edge so the flash never samples a changing level
  always @(negedge link_clk_in) begin
    write_en_n_out <= 1'b1;
    out_en_n_out   <= quiet_in;
    addr_out       <= start_addr_in;
    // deselect after load
    // the user design only runs once done is up, so it gates the request
    sel_n_out      <= done_in && done_pin;
  end

  // shared-edge capture
  // a released bus carries nothing, so only driven words are taken
  always @(posedge link_clk_in) begin
    if (data_oe_in === 1'b1) begin
      words.push_back(data_in);
    end
    if (!prog_n_in) begin
      init_n             <= 1'b0;
      busy_n             <= 1'b1;
      startup            <= 1'b0;
      done_pin           <= 1'b0;
      user_pins_live     <= 1'b0;
      revision_select_oe <= 1'b0;
      chain_select_out_n <= 1'b1;
    end else if (crc_err_in) begin
      init_n   <= 1'b0;
      done_pin <= 1'b0;
    end else begin
      if (!init_n) begin
        init_n <= 1'b1;
        mode   <= MODE_PINS;
      end
      busy_n <= 1'b0;
      if (words.size() >= BITSTREAM_WORDS - 1) begin
        startup <= 1'b1;
      end
      if (startup) begin
        done_pin       <= 1'b1;
        user_pins_live <= 1'b1;
      end
    end
  end

  assign unused_pull_up = !done_pin && !io_pullup_disable_in;
endmodule : pcfl_loader_model

// file: test/test_parallel_config_burst_load.sv
`timescale 1ns/100ps
`include "pcfl_map.svh"

module test_parallel_config_burst_load import pcfl_pkg::*;;
  logic                    clk, link_clk, srst, prog_we, quiet, done, oe, ready;
  logic                    sel_n, out_en_n, write_en_n, crc_err, pullup_dis;
  logic [`PCFL_IDX_W-1:0]  prog_addr;
  logic [`PCFL_DATA_W-1:0] prog_data, data;
  logic [`PCFL_ADDR_W-1:0] start_addr, addr;
  int                      err_count = 0;
  int                      n_compared = 0;
  int                      seed = 32'hC4CEB67C;

  pcfl_flash_top i_dut (.CLK_IN(clk), .SRST_IN(srst), .LINK_CLK_IN(link_clk),
    .ADDR_IN(addr), .SEL_N_IN(sel_n), .OUT_EN_N_IN(out_en_n), .WRITE_EN_N_IN(write_en_n),
    .PROG_WE_IN(prog_we), .PROG_ADDR_IN(prog_addr), .PROG_DATA_IN(prog_data),
    .DATA_OUT(data), .DATA_OE_OUT(oe), .READY_OUT(ready));

  pcfl_loader_model i_loader (.link_clk_in(link_clk), .prog_n_in(!srst), .crc_err_in(crc_err),
    .io_pullup_disable_in(pullup_dis), .data_in(data), .data_oe_in(oe),
    .start_addr_in(start_addr), .quiet_in(quiet), .done_in(done), .addr_out(addr),
    .sel_n_out(sel_n), .out_en_n_out(out_en_n), .write_en_n_out(write_en_n));

  // clocks: link clock offset so the two never share an edge
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #6 link_clk = ~link_clk;
  end

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t word got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // mode 0: zero start address, 1: random start address, 2: output enable high
  task automatic run_pass(input int mode);
    int base;
    int n;
    int exp_mem[16];
    srst = 1'b1;
    quiet = (mode == 2);
    done = 1'b0;
    crc_err = 1'b0;
    pullup_dis = 1'($random(seed));
    start_addr = (mode == 0) ? '0 : 23'($random(seed));
    repeat (24) @(negedge clk);
    check_bit(i_loader.init_n, 1'b0);
    check_bit(i_loader.unused_pull_up, !pullup_dis);
    srst = 1'b0;
    i_loader.words.delete();
    foreach (exp_mem[i]) exp_mem[i] = 0;
    base = int'(start_addr[3:0]);
    fork
      begin
        repeat (20) @(posedge clk);
        #1 check_bit(ready, 1'b0);
        @(posedge clk);
        #1 check_bit(ready, 1'b1);
      end
      begin
        // array loaded before the address is latched
        repeat (6) @(negedge link_clk);
        for (int i = 0; i < 6; i++) begin
          prog_we = 1'b1;
          prog_addr = 4'(base + i);
          prog_data = 16'($random(seed));
          exp_mem[(base + i) % 16] = int'(prog_data);
          @(negedge link_clk);
        end
        prog_we = 1'b0;
      end
    join
    // the quiet pass also carries a crc error once init has been released
    @(negedge link_clk);
    crc_err = (mode == 2);
    for (int k = 0; k < 300 && i_loader.words.size() < 20; k++) @(negedge link_clk);
    if (mode == 2) begin
      check_bit(oe, 1'b0);
      check_word(16'(i_loader.words.size()), 16'h0000);
      check_bit(i_loader.init_n, 1'b0);
      check_bit(i_loader.done_pin, 1'b0);
    end else begin
      // burst wraps past the array end
      for (int k = 0; k < 20; k++) begin
        check_word(i_loader.words[k], 16'(exp_mem[(base + k) % 16]));
      end
      @(negedge clk);
      done = 1'b1;
      repeat (4) @(negedge link_clk);
      check_bit(oe, 1'b0);
      n = i_loader.words.size();
      repeat (10) @(negedge link_clk);
      check_word(16'(i_loader.words.size()), 16'(n));
      check_bit(sel_n, 1'b1);
      check_bit(i_loader.startup, 1'b1);
      check_bit(i_loader.done_pin, 1'b1);
      check_bit(i_loader.user_pins_live, 1'b1);
      check_bit(i_loader.unused_pull_up, 1'b0);
      check_bit(i_loader.init_n, 1'b1);
      check_word(16'(i_loader.mode), 16'h0006);
      check_bit(i_loader.busy_n, 1'b0);
      check_bit(i_loader.revision_select_oe, 1'b0);
      check_bit(i_loader.chain_select_out_n, 1'b1);
    end
  endtask : run_pass

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    prog_we = 1'b0;
    prog_addr = '0;
    prog_data = '0;
    quiet = 1'b0;
    done = 1'b0;
    crc_err = 1'b0;
    pullup_dis = 1'b0;
    start_addr = '0;
    for (int m = 0; m < 3; m++) run_pass(m);
    end_sim();
  end

  // watchdog: three passes need well under ten microseconds
  initial begin
    #50000;
    err_count++;
    $display("FAIL %0t watchdog expired", $time);
    end_sim();
  end
endmodule : test_parallel_config_burst_load
